// file: host_controller_port_tb_top.sv
// Bench joining host and device ends through the port interface.
// Assumes one 200 MHz clock; frame shortened to 90 cycles.
`timescale 1ns/1ps
module host_controller_port_tb_top;
  import host_port_pkg::*;
  logic              mclk_i, arst_n_i, req, req_write, prgm_pin, loss;
  logic [ADDR_W-1:0] req_addr;
  logic [DATA_W-1:0] req_wdata, rdata, oh_data;
  logic [4:0]        oh_addr;
  logic              busy, done, irq, clk_lb, fac_lb, fpulse, dcc_en, pmode;
  int                n_fail, cmp_count, cyc, npulse;

  host_port_if bif ();
  line_iface_device #(.FRAME_CYCLES(90)) u_line_iface_device (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .bus(bif),
    .overhead_program_mode_pin_i(prgm_pin), .carrier_loss_input_i(loss),
    .line_clock_loopback_out_o(clk_lb), .line_facility_loopback_out_o(fac_lb),
    .tx_dcc_frame_pulse_o(fpulse), .tx_dcc_enable_o(dcc_en),
    .oh_rd_addr_i(oh_addr), .oh_rd_data_o(oh_data), .program_mode_o(pmode));
  line_iface_host u_line_iface_host (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .bus(bif), .req_i(req),
    .req_write_i(req_write), .req_addr_i(req_addr), .req_wdata_i(req_wdata),
    .busy_o(busy), .done_o(done), .rdata_o(rdata), .irq_o(irq));
  host_port_assertions u_host_port_assertions (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .addr(bif.addr), .rd_not_wr(bif.rd_not_wr),
    .sel_n(bif.sel_n), .ready_n(bif.ready_n), .host_d_oe(bif.host_d_oe),
    .dev_d_oe(bif.dev_d_oe), .int_pull_oe(bif.int_pull_oe));

  // Clock, 5 ns period
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end

  // Frame pulse count and hang guard; whole run needs about 400 cycles
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (fpulse === 1'b1) npulse <= npulse + 1;
    if (cyc == 4000) begin
      n_fail = n_fail + 1;
      results();
    end
  end

  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t flag got %h exp %h", $time, got, exp);
    end
  endtask

  // One access; returns at a clock edge once the port has closed
  task automatic acc(input logic w, input logic [10:0] a, input logic [7:0] d);
    int n;
    @(posedge mclk_i);
    req <= 1'b1;
    req_write <= w;
    req_addr <= a;
    req_wdata <= d;
    @(posedge mclk_i);
    req <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk_i);
      #1;
      n++;
    end while (done !== 1'b1 && n < 10);
    cmp1(done, 1'b1);
    cmp1(busy, 1'b1);
    repeat (2) @(posedge mclk_i);
    #1;
    cmp1(busy, 1'b0);
    @(posedge mclk_i);
  endtask

  task automatic wr(input logic [10:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask

  task automatic rd(input logic [10:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    cmp(rdata, exp);
  endtask

  task automatic t_ctrl;
    rd(CTRL_ADDR, CTRL_RESET);
    wr(CTRL_ADDR, 8'h02);
    cmp1(clk_lb, 1'b1);
    cmp1(fac_lb, 1'b0);
    wr(CTRL_ADDR, 8'hA4);
    cmp1(clk_lb, 1'b0);
    cmp1(fac_lb, 1'b1);
    rd(CTRL_ADDR, 8'hA4);
    wr(CTRL_ADDR, 8'h01);
    cmp1(pmode, 1'b1);
    cmp1(dcc_en, 1'b0);
    wr(CTRL_ADDR, 8'h00);
    wr(11'h7FF, 8'h5A);
    rd(11'h7FF, 8'h00);
  endtask

  task automatic t_host_interrupt_n;
    wr(MASK_ADDR, STAT_EVT_MASK);
    loss <= 1'b1;
    repeat (8) @(posedge mclk_i);
    rd(STAT_ADDR, 8'h03);
    cmp1(irq, 1'b1);
    wr(STAT_ADDR, 8'h02);
    cmp1(irq, 1'b0);
    loss <= 1'b0;
    repeat (8) @(posedge mclk_i);
    rd(STAT_ADDR, 8'h04);
    cmp1(irq, 1'b1);
    wr(MASK_ADDR, 8'h00);
    cmp1(irq, 1'b0);
    wr(STAT_ADDR, STAT_EVT_MASK);
    rd(STAT_ADDR, 8'h00);
  endtask

  // Refresh, then program mode by pin; a 90-cycle wait spans one frame
  task automatic t_ovh;
    int p0;
    wr(TXOH_BASE, 8'h11);
    p0 = npulse;
    repeat (90) @(posedge mclk_i);
    cmp(8'(npulse - p0), 8'h01);
    rd(TXOH_BASE, AUTO_VAL0);
    rd(TXOH_BASE + 11'h001, AUTO_VAL1);
    prgm_pin <= 1'b1;
    repeat (6) @(posedge mclk_i);
    cmp1(pmode, 1'b1);
    cmp1(dcc_en, 1'b0);
    wr(TXOH_BASE, 8'h80);
    wr(TXOH_BASE + 11'h01F, 8'h01);
    p0 = npulse;
    repeat (90) @(posedge mclk_i);
    cmp(8'(npulse - p0), 8'h00);
    rd(TXOH_BASE, 8'h80);
    rd(TXOH_BASE + 11'h001, AUTO_VAL1);
    rd(TXOH_BASE + 11'h01F, 8'h01);
    rd(11'h01F, 8'h00);
    oh_addr <= 5'h00;
    repeat (2) @(posedge mclk_i);
    cmp(oh_data, 8'h80);
    prgm_pin <= 1'b0;
  endtask

  // Reset in mid-run: loopbacks drop, port idles, control reads back cleared
  task automatic t_rst;
    wr(CTRL_ADDR, 8'h06);
    cmp1(fac_lb, 1'b1);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    cmp1(clk_lb, 1'b0);
    cmp1(bif.ready_n, 1'b1);
    arst_n_i <= 1'b1;
    rd(CTRL_ADDR, CTRL_RESET);
    cmp1(fac_lb, 1'b0);
  endtask

  // Main sequence
  initial begin
    {arst_n_i, req, req_write, prgm_pin, loss} = '0;
    req_addr = '0;
    req_wdata = '0;
    oh_addr = '0;
    {n_fail, cmp_count, cyc, npulse} = '0;
    repeat (10) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    t_ctrl();
    t_host_interrupt_n();
    t_ovh();
    t_rst();
    results();
  end
endmodule

// file: host_port_assertions.sv
// Checker on the controller port signals between host and device ends.
// Assumes one clock domain; reset low disables every check.
`timescale 1ns/1ps
module host_port_assertions (
  // Clock and reset
  input wire logic        mclk_i,
  input wire logic        arst_n_i,
  // Port signals
  input wire logic [10:0] addr,
  input wire logic        rd_not_wr,
  input wire logic        sel_n,
  input wire logic        ready_n,
  input wire logic        host_d_oe,
  input wire logic        dev_d_oe,
  input wire logic        int_pull_oe
);
  // One domain, so shared clocking and disable
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!arst_n_i);

  a_ready_after_sel: assert property ($fell(sel_n) |=> !ready_n)
    else $error("ready not low the cycle after select");
  a_ready_two_cyc: assert property ($fell(ready_n) |=> !ready_n ##1 ready_n)
    else $error("ready low for the wrong length");
  a_ready_needs_sel: assert property ($fell(ready_n) |-> !sel_n)
    else $error("ready given without select");
  a_sel_gap: assert property ($rose(ready_n) |-> sel_n)
    else $error("select low while ready rises");
  a_sel_two_cyc: assert property ($fell(sel_n) |=> !sel_n ##1 sel_n)
    else $error("select held for the wrong length");
  a_host_holds: assert property
    (!sel_n && ready_n |=> !sel_n && $stable(addr) && $stable(rd_not_wr))
    else $error("host changed access before ready");
  // Data bus turn-around: one driver, each only in its own access kind
  a_read_drive: assert property (dev_d_oe |-> !sel_n && rd_not_wr && !ready_n)
    else $error("device drives data outside a read");
  a_write_drive: assert property (host_d_oe |-> !sel_n && !rd_not_wr)
    else $error("host drives data outside a write");
  a_one_driver: assert property (!(dev_d_oe && host_d_oe))
    else $error("both ends drive the data bus");

  // Main scenarios reached
  c_read: cover property ($fell(sel_n) && rd_not_wr);
  c_write: cover property ($fell(sel_n) && !rd_not_wr);
  c_host_interrupt_n: cover property ($rose(int_pull_oe));
endmodule

// file: host_port_if.sv
// Parallel controller port between host and device.
// Resolves the shared data lines and the open-drain interrupt from enables.
`timescale 1ns/1ps
interface host_port_if;
  import host_port_pkg::*;

  logic [ADDR_W-1:0] addr;
  logic              rd_not_wr;
  logic              sel_n;
  logic              ready_n;
  logic [DATA_W-1:0] host_d_out;
  logic              host_d_oe;
  logic [DATA_W-1:0] dev_d_out;
  logic              dev_d_oe;
  logic              int_pull_oe;
  logic [DATA_W-1:0] data;
  logic              host_interrupt_n;

  // Wire levels: whoever enables drives, otherwise the pull-up wins
  assign data = dev_d_oe ? dev_d_out : (host_d_oe ? host_d_out : BUS_PULLUP);
  assign host_interrupt_n = ~int_pull_oe;

  modport device (input addr, input rd_not_wr, input sel_n, input data,
                  output ready_n, output dev_d_out, output dev_d_oe, output int_pull_oe);
  modport host (output addr, output rd_not_wr, output sel_n, output host_d_out,
                output host_d_oe, input data, input ready_n, input host_interrupt_n);
endinterface

// file: host_port_pkg.sv
// Shared constants for the controller port: bus widths, register map,
// field positions, reset values and frame timing.
// Assumes a single 200 MHz clock shared by both ends of the port.
package host_port_pkg;

  // Bus widths
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;

  // Register and overhead RAM map
  localparam logic [10:0] CTRL_ADDR  = 11'h000;
  localparam logic [10:0] STAT_ADDR  = 11'h001;
  localparam logic [10:0] MASK_ADDR  = 11'h002;
  localparam logic [10:0] TXOH_BASE  = 11'h400;
  localparam int          TXOH_AW    = 5;
  localparam int          TXOH_DEPTH = 32;

  // Control register fields
  localparam int CTRL_PRGM_BIT    = 0;
  localparam int CTRL_LINE_CLOCK_LOOPBACK_OUT_BIT = 1;
  localparam int CTRL_FLB_BIT     = 2;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Status and mask layout: live level plus two sticky events
  localparam int STAT_LOSS_LVL  = 0;
  localparam int STAT_LOSS_RISE = 1;
  localparam int STAT_LOSS_FALL = 2;
  localparam logic [7:0] STAT_EVT_MASK = 8'h06;
  localparam logic [7:0] MASK_RESET    = 8'h00;

  // Bus idle level seen when nobody drives the data lines
  localparam logic [7:0] BUS_PULLUP = 8'hFF;

  // Designated overhead bytes refreshed each frame and their values
  localparam logic [4:0] AUTO_LOC0 = 5'h00;
  localparam logic [4:0] AUTO_LOC1 = 5'h01;
  localparam logic [7:0] AUTO_VAL0 = 8'hF6;
  localparam logic [7:0] AUTO_VAL1 = 8'h28;

  // Frame timing: 125 us frame at a 5 ns clock
  localparam int CLK_NS     = 5;
  localparam int FRAME_NS   = 125000;
  localparam int FRAME_CYC  = FRAME_NS / CLK_NS;
  localparam int FRAME_ROWS = 9;
  localparam int PULSE_AT   = 0;

endpackage

// file: line_iface_device.sv
// Device end of the controller port: control, status and mask registers,
// transmit overhead RAM with per-frame refresh, loopback mirrors, interrupt.
// Assumes the host runs on mclk_i; the two status pins are asynchronous.
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/1ps
module line_iface_device
  import host_port_pkg::*;
#(
  parameter int FRAME_CYCLES = FRAME_CYC
) (
  // Clock and reset
  input  wire logic                mclk_i,
  input  wire logic                arst_n_i,
  // Controller port
  host_port_if.device              bus,
  // Line-side pins
  input  wire logic                overhead_program_mode_pin_i,
  input  wire logic                carrier_loss_input_i,
  output logic                     line_clock_loopback_out_o,
  output logic                     line_facility_loopback_out_o,
  // Serial transmit overhead port control
  output logic                     tx_dcc_frame_pulse_o,
  output logic                     tx_dcc_enable_o,
  // Framer read port into transmit overhead RAM
  input  wire logic [TXOH_AW-1:0]  oh_rd_addr_i,
  output logic [DATA_W-1:0]        oh_rd_data_o,
  output logic                     program_mode_o
);
  localparam int CNT_W   = $clog2(FRAME_CYCLES + 1);
  localparam int AUTO_AT = FRAME_CYCLES / FRAME_ROWS;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_ACK  = 1'b1
  } acc_state_e;

  acc_state_e        state;
  acc_state_e        next_state;
  logic [7:0]        ctrl;
  logic [7:0]        status_evt;
  logic [7:0]        mask;
  logic [7:0]        rdata;
  logic [7:0]        txoh [TXOH_DEPTH];
  logic [CNT_W-1:0]  frame_cnt;
  logic              prgm_pin;
  logic              loss_lvl;
  logic              loss_rise;
  logic              loss_fall;

  // Pin synchronisers for the asynchronous mode and carrier pins
  pin_sync u_prgm_sync (
    .mclk_i   (mclk_i),
    .arst_n_i (arst_n_i),
    .pin_i    (overhead_program_mode_pin_i),
    .level_o  (prgm_pin),
    .rise_o   (),
    .fall_o   ()
  );

  pin_sync u_loss_sync (
    .mclk_i   (mclk_i),
    .arst_n_i (arst_n_i),
    .pin_i    (carrier_loss_input_i),
    .level_o  (loss_lvl),
    .rise_o   (loss_rise),
    .fall_o   (loss_fall)
  );

  // Access decode; a new access starts only from idle with select low
  wire        take      = (state == ST_IDLE) && !bus.sel_n;
  wire        wr_take   = take && !bus.rd_not_wr;
  wire [10:0] a         = bus.addr;
  wire [7:0]  wdata     = bus.data;
  wire        ctrl_we   = wr_take && (a == CTRL_ADDR);
  wire        stat_we   = wr_take && (a == STAT_ADDR);
  wire        mask_we   = wr_take && (a == MASK_ADDR);
  wire        in_txoh   = (a[ADDR_W-1:TXOH_AW] == TXOH_BASE[ADDR_W-1:TXOH_AW]);
  wire        txoh_we   = wr_take && in_txoh;
  wire [TXOH_AW-1:0] txoh_idx = a[TXOH_AW-1:0];

  // Program mode and refresh timing
  wire prgm      = prgm_pin || ctrl[CTRL_PRGM_BIT];
  wire frame_end = (frame_cnt == CNT_W'(FRAME_CYCLES - 1));
  wire auto_we   = !prgm && (frame_cnt == CNT_W'(AUTO_AT));

  // Status view: live carrier level plus sticky events
  wire [7:0] status_view = status_evt | {7'b0, loss_lvl};
  wire       irq         = |(status_evt & mask);

  // Read mux; unmapped addresses read as zero
  wire [7:0] rd_mux = (a == CTRL_ADDR) ? ctrl :
                      (a == STAT_ADDR) ? status_view :
                      (a == MASK_ADDR) ? mask :
                      in_txoh          ? txoh[txoh_idx] : 8'h00;

  // Access sequencer: ready held low until the host lifts select
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (!bus.sel_n) begin
          next_state = ST_ACK;
        end
      end
      ST_ACK: begin
        if (bus.sel_n) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ST_IDLE;
      rdata <= 8'h00;
    end else begin
      state <= next_state;
      if (take) begin
        rdata <= rd_mux;
      end
    end
  end

  // Control and mask registers
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl <= CTRL_RESET;
      mask <= MASK_RESET;
    end else begin
      if (ctrl_we) begin
        ctrl <= wdata;
      end
      if (mask_we) begin
        mask <= wdata;
      end
    end
  end

  // Sticky events: write one clears, a new event in the same cycle wins
  wire [7:0] evt_set = {5'b0, loss_fall, loss_rise, 1'b0};
  wire [7:0] evt_clr = stat_we ? (wdata & STAT_EVT_MASK) : 8'h00;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      status_evt <= 8'h00;
    end else begin
      status_evt <= (status_evt & ~evt_clr) | evt_set;
    end
  end

  // Frame counter runs free; program mode does not stop framing
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      frame_cnt <= '0;
    end else if (frame_end) begin
      frame_cnt <= '0;
    end else begin
      frame_cnt <= frame_cnt + CNT_W'(1);
    end
  end

  // Overhead RAM: refresh skipped in program mode, so host bytes survive
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int i = 0; i < TXOH_DEPTH; i++) begin
        txoh[i] <= 8'h00;
      end
      oh_rd_data_o <= 8'h00;
    end else begin
      if (auto_we) begin
        txoh[AUTO_LOC0] <= AUTO_VAL0;
        txoh[AUTO_LOC1] <= AUTO_VAL1;
      end
      if (txoh_we) begin
        txoh[txoh_idx] <= wdata;
      end
      oh_rd_data_o <= txoh[oh_rd_addr_i];
    end
  end

  // Serial port control; pulse marks the frame start ahead of the first bit
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tx_dcc_frame_pulse_o <= 1'b0;
    end else begin
      tx_dcc_frame_pulse_o <= !prgm && (frame_cnt == CNT_W'(PULSE_AT));
    end
  end

  assign tx_dcc_enable_o = !prgm;
  assign program_mode_o  = prgm;

  // Port outputs: ready and data lines only while an access is open
  assign bus.ready_n     = !(state == ST_ACK);
  assign bus.dev_d_oe    = (state == ST_ACK) && bus.rd_not_wr && !bus.sel_n;
  assign bus.dev_d_out   = rdata;
  assign bus.int_pull_oe = irq;

  // Loopback mirrors
  assign line_clock_loopback_out_o    = ctrl[CTRL_LINE_CLOCK_LOOPBACK_OUT_BIT];
  assign line_facility_loopback_out_o = ctrl[CTRL_FLB_BIT];
endmodule

// file: line_iface_host.sv
// Host end of the controller port: turns one-cycle user requests into
// select/ready accesses and returns read data.
// Assumes the device shares mclk_i, so port inputs need no synchroniser.
`timescale 1ns/1ps
module line_iface_host
  import host_port_pkg::*;
(
  // Clock and reset
  input  wire logic                mclk_i,
  input  wire logic                arst_n_i,
  // Controller port
  host_port_if.host                bus,
  // User request
  input  wire logic                req_i,
  input  wire logic                req_write_i,
  input  wire logic [ADDR_W-1:0]   req_addr_i,
  input  wire logic [DATA_W-1:0]   req_wdata_i,
  // User answer
  output logic                     busy_o,
  output logic                     done_o,
  output logic [DATA_W-1:0]        rdata_o,
  output logic                     irq_o
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ACT  = 2'b01,
    ST_REL  = 2'b11
  } host_state_e;

  host_state_e       state;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic              is_write;

  wire take  = (state == ST_IDLE) && req_i;
  wire ready = !bus.ready_n;

  // Access sequencer: hold everything until ready, then wait for it to lift
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state    <= ST_IDLE;
      addr     <= '0;
      wdata    <= '0;
      is_write <= 1'b0;
      rdata_o  <= '0;
      done_o   <= 1'b0;
    end else begin
      done_o <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          if (take) begin
            addr     <= req_addr_i;
            wdata    <= req_wdata_i;
            is_write <= req_write_i;
            state    <= ST_ACT;
          end
        end
        ST_ACT: begin
          if (ready) begin
            if (!is_write) begin
              rdata_o <= bus.data;
            end
            done_o <= 1'b1;
            state  <= ST_REL;
          end
        end
        ST_REL: begin
          if (!ready) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Port drive: select and write data only while the access is open
  assign bus.sel_n      = !(state == ST_ACT);
  assign bus.addr       = addr;
  assign bus.rd_not_wr  = !is_write;
  assign bus.host_d_out = wdata;
  assign bus.host_d_oe  = (state == ST_ACT) && is_write;
  assign busy_o         = (state != ST_IDLE);
  assign irq_o          = !bus.host_interrupt_n;
endmodule

// file: pin_sync.sv
// Three-stage pin synchroniser with agreement filter and edge pulses.
// Assumes the pin is asynchronous to mclk_i.
`timescale 1ns/1ps
module pin_sync (
  // Clock and reset
  input  wire logic mclk_i,
  input  wire logic arst_n_i,
  // Pin and filtered view
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic s1;
  logic s2;
  logic s3;
  logic stable;
  wire  agree = (s2 == s3);

  // Stage one feeds only stage two, to keep metastability contained
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      stable <= 1'b0;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      if (agree) begin
        stable <= s3;
      end
    end
  end

  // Edges are taken on the filtered level only
  assign level_o = stable;
  assign rise_o  = agree && s3 && !stable;
  assign fall_o  = agree && !s3 && stable;
endmodule
